// ---- rtl/flloc_top.sv ----
// fault distance locator: trigger, block check, loop choice, division, events, history
// assumes all inputs come from logic on clk; tick marks one program cycle
//
// How it works
// - selectable internal binary signal triggers locator
// - blocked calculation records nothing for trigger
// - phase-neutral loops only with earth voltages
// - loop chosen from phases over threshold
// - no current condition means no record
// - trigger current threshold, 0.1 nominal steps
// - reactance per length setting, default 0.125
// - loops from fundamental magnitudes, 5 ms base
// - block input sampled at cycle start
// - block at pick-up raises blocked, abandons
// - on/off events for triggered and calculation
// - per-event choice of on, off stored
// - every event carries its time stamp
// - resettable cumulative trigger counter
// - keep twelve newest records only
// - record holds time, type, direction, values
// - setting group change applies at once
`timescale 1ns/1ps
`default_nettype none
module flloc_top (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  tick,
  input  wire logic [31:0]           trig_src,
  input  wire logic                  calc_block,
  input  wire logic                  pe_volt_ok,
  input  wire flloc_pkg::flloc_meas_t meas,
  input  wire logic [1:0]            fault_dir,
  input  wire logic [2:0]            set_group,
  input  wire logic [31:0]           time_ms,
  input  wire logic [7:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata,
  output logic                       evt_valid,
  output logic [1:0]                 evt_code,
  output logic [31:0]                evt_stamp,
  output logic                       blocked,
  output logic                       irq
);
  logic [11:0]                ctrl_ff;
  logic [3:0]                 sts_ff, mask_ff, pend_ff;
  logic [31:0]                cnt_ff, rdata_ff, stamp_ff, x_ff, dist_ff, evt_stamp_ff;
  logic [15:0]                ctnom_ff;
  logic [3:0]                 rsel_ff, wp_ff, num_ff;
  logic [8:0]                 thr_ff [flloc_pkg::NGRP];
  logic [12:0]                xpk_ff [flloc_pkg::NGRP];
  flloc_pkg::flloc_rec_t      rec_ff [flloc_pkg::HIST];
  flloc_pkg::flloc_state_t    st_ff;
  flloc_pkg::flloc_meas_t     snap_ff;
  flloc_pkg::flloc_ftype_t    ft_ff;
  logic                       trig_prev_ff, pe_ff, calc_on_ff, blk_ff;
  logic                       evt_valid_ff, irq_ff;
  logic [1:0]                 evt_code_ff, dir_ff;
  logic [31:0]                dvd_ff, dvs_ff, q_ff;
  logic [32:0]                rem_ff;
  logic [5:0]                 dcnt_ff;

  // selection of trigger and live settings
  // ctrl [4:0] picks the trigger, [11:8] enable events; kept apart so a high select mutes no event
  wire        trig_now  = trig_src[ctrl_ff[4:0]];
  wire        trig_rise = tick & trig_now & ~trig_prev_ff;
  wire        trig_fall = tick & ~trig_now & trig_prev_ff;
  wire [8:0]  thr_act   = thr_ff[set_group];
  wire [12:0] xpk_act   = xpk_ff[set_group];
  wire [15:0] thr_cpu   = 16'(thr_act * flloc_pkg::THR_SCALE);
  wire        ov_a      = snap_ff.i_a > thr_cpu;
  wire        ov_b      = snap_ff.i_b > thr_cpu;
  wire        ov_c      = snap_ff.i_c > thr_cpu;

  // loop choice; single phases need earth voltages
  flloc_pkg::flloc_ftype_t ft_sel;
  always_comb begin
    case ({ov_a, ov_b, ov_c})
      3'b111:  ft_sel = flloc_pkg::FT_ABC;
      3'b110:  ft_sel = flloc_pkg::FT_AB;
      3'b011:  ft_sel = flloc_pkg::FT_BC;
      3'b101:  ft_sel = flloc_pkg::FT_CA;
      3'b100:  ft_sel = pe_ff ? flloc_pkg::FT_AN : flloc_pkg::FT_NONE;
      3'b010:  ft_sel = pe_ff ? flloc_pkg::FT_BN : flloc_pkg::FT_NONE;
      3'b001:  ft_sel = pe_ff ? flloc_pkg::FT_CN : flloc_pkg::FT_NONE;
      default: ft_sel = flloc_pkg::FT_NONE;
    endcase
  end

  // loop voltage and current; a two-phase loop sees the sum of its two phase currents
  logic [15:0] u_loop;
  logic [16:0] i_loop;
  always_comb begin
    case (ft_sel)
      flloc_pkg::FT_BC: begin u_loop = snap_ff.u_bc; i_loop = snap_ff.i_b + snap_ff.i_c; end
      flloc_pkg::FT_CA: begin u_loop = snap_ff.u_ca; i_loop = snap_ff.i_c + snap_ff.i_a; end
      flloc_pkg::FT_AN: begin u_loop = snap_ff.u_an; i_loop = {1'b0, snap_ff.i_a}; end
      flloc_pkg::FT_BN: begin u_loop = snap_ff.u_bn; i_loop = {1'b0, snap_ff.i_b}; end
      flloc_pkg::FT_CN: begin u_loop = snap_ff.u_cn; i_loop = {1'b0, snap_ff.i_c}; end
      default:          begin u_loop = snap_ff.u_ab; i_loop = snap_ff.i_a + snap_ff.i_b; end
    endcase
  end
  wire [31:0] x_dvd   = 32'(u_loop * flloc_pkg::X_SCALE);
  wire [31:0] x_dvs   = 32'(i_loop * ctnom_ff);
  wire [31:0] d_dvd   = 32'(q_ff * flloc_pkg::D_SCALE);
  wire [31:0] i_pri   = 32'(snap_ff.i_a * ctnom_ff);
  wire [31:0] d_chk   = 32'(x_ff * flloc_pkg::D_SCALE);

  // shared serial divider, one quotient bit per clock; zero divisor gives all ones
  wire [32:0] rem_sh  = {rem_ff[31:0], dvd_ff[31]};
  wire        rem_ge  = rem_sh >= {1'b0, dvs_ff};
  wire        div_end = dcnt_ff == 6'h20;
  wire        go_div  = (st_ff == flloc_pkg::S_EVAL && ft_sel != flloc_pkg::FT_NONE) ||
                        (st_ff == flloc_pkg::S_DIVX && div_end);
  always_ff @(posedge clk) begin
    if (rst || go_div) begin
      rem_ff  <= 33'h0;
      dcnt_ff <= 6'h0;
      q_ff    <= rst ? 32'h0 : q_ff;
      dvd_ff  <= (st_ff == flloc_pkg::S_EVAL) ? x_dvd : d_dvd;
      dvs_ff  <= (st_ff == flloc_pkg::S_EVAL) ? x_dvs : {19'h0, xpk_act};
    end else if (!div_end) begin
      rem_ff  <= rem_ge ? rem_sh - {1'b0, dvs_ff} : rem_sh;
      dvd_ff  <= {dvd_ff[30:0], 1'b0};
      q_ff    <= {q_ff[30:0], rem_ge};
      dcnt_ff <= dcnt_ff + 6'h1;
    end
  end

  // sequencer
  flloc_pkg::flloc_state_t nxt_st;
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      flloc_pkg::S_IDLE:  if (trig_rise && !calc_block) begin
        nxt_st = flloc_pkg::S_EVAL;
      end
      flloc_pkg::S_EVAL:  nxt_st = (ft_sel == flloc_pkg::FT_NONE) ?
                                   flloc_pkg::S_IDLE : flloc_pkg::S_DIVX;
      flloc_pkg::S_DIVX:  if (div_end) begin
        nxt_st = flloc_pkg::S_DIVD;
      end
      flloc_pkg::S_DIVD:  if (div_end) begin
        nxt_st = flloc_pkg::S_STORE;
      end
      default:            nxt_st = flloc_pkg::S_IDLE;
    endcase
  end

  // snapshot at the trigger tick; block is read in the same tick, before evaluation
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff        <= flloc_pkg::S_IDLE;
      trig_prev_ff <= 1'b0;
      blk_ff       <= 1'b0;
      pe_ff        <= 1'b0;
      snap_ff      <= '0;
      dir_ff       <= 2'h0;
      ft_ff        <= flloc_pkg::FT_NONE;
      x_ff         <= 32'h0;
      dist_ff      <= 32'h0;
      stamp_ff     <= 32'h0;
    end else begin
      st_ff <= nxt_st;
      if (tick) begin
        trig_prev_ff <= trig_now;
      end
      if (trig_rise) begin
        blk_ff <= calc_block;
      end else if (trig_fall) begin
        blk_ff <= 1'b0;
      end
      if (trig_rise && st_ff == flloc_pkg::S_IDLE) begin
        snap_ff  <= meas;
        pe_ff    <= pe_volt_ok;
        dir_ff   <= fault_dir;
        stamp_ff <= time_ms;
      end
      if (st_ff == flloc_pkg::S_EVAL) begin
        ft_ff <= ft_sel;
      end
      if (st_ff == flloc_pkg::S_DIVX && div_end) begin
        x_ff <= q_ff;
      end
      if (st_ff == flloc_pkg::S_DIVD && div_end) begin
        dist_ff <= q_ff;
      end
    end
  end

  // twelve-entry history, oldest overwritten
  wire store = st_ff == flloc_pkg::S_STORE;
  flloc_pkg::flloc_rec_t rec_new;
  assign rec_new = '{stamp: stamp_ff, calc: 1'b1, ftype: ft_ff, dir: dir_ff,
                     grp: set_group, x_mohm: x_ff, i_pu: snap_ff.i_a,
                     i_pri: i_pri, dist_m: dist_ff};
  for (genvar e = 0; e < flloc_pkg::HIST; e++) begin : g_rec
    always_ff @(posedge clk) begin
      if (rst) begin
        rec_ff[e] <= '0;
      end else if (store && wp_ff == 4'(e)) begin
        rec_ff[e] <= rec_new;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_ff  <= 4'h0;
      num_ff <= 4'h0;
    end else if (store) begin
      wp_ff  <= (wp_ff == 4'(flloc_pkg::HIST - 1)) ? 4'h0 : wp_ff + 4'h1;
      num_ff <= (num_ff == 4'(flloc_pkg::HIST)) ? num_ff : num_ff + 4'h1;
    end
  end
  // rsel counts back from the newest record
  wire [4:0] age_idx = 5'(wp_ff) + 5'(flloc_pkg::HIST - 1) - 5'(rsel_ff);
  wire [3:0] rd_idx  = (age_idx >= 5'(flloc_pkg::HIST)) ? 4'(age_idx - 5'(flloc_pkg::HIST)) : age_idx[3:0];
  flloc_pkg::flloc_rec_t rec_rd;
  assign rec_rd = rec_ff[rd_idx];

  // events: each one is queued, the lowest pending goes out each clock
  wire [3:0] ev_new = {trig_fall & calc_on_ff, store, trig_fall, trig_rise};
  wire [3:0] ev_pick = pend_ff & (~pend_ff + 4'h1);
  wire [1:0] ev_idx  = ev_pick[3] ? 2'h3 : ev_pick[2] ? 2'h2 : ev_pick[1] ? 2'h1 : 2'h0;
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_ff      <= 4'h0;
      calc_on_ff   <= 1'b0;
      evt_valid_ff <= 1'b0;
      evt_code_ff  <= 2'h0;
      evt_stamp_ff <= 32'h0;
    end else begin
      pend_ff      <= (pend_ff & ~ev_pick) | ev_new;
      calc_on_ff   <= store | (calc_on_ff & ~trig_fall);
      evt_valid_ff <= (pend_ff != 4'h0) && ctrl_ff[8 + ev_idx];
      evt_code_ff  <= ev_idx;
      evt_stamp_ff <= time_ms;
    end
  end

  // register slave
  wire        grp_hit = reg_addr[7:6] == flloc_pkg::A_GRP_HI;
  wire [2:0]  grp_idx = reg_addr[5:3];
  wire        wr_sts  = reg_wr && reg_addr == flloc_pkg::A_STS;
  wire        wr_cnt  = reg_wr && reg_addr == flloc_pkg::A_CNT;
  wire [3:0]  ev_sts  = {(st_ff == flloc_pkg::S_EVAL) && ft_sel == flloc_pkg::FT_NONE,
                         trig_rise & calc_block, store, trig_rise};
  wire [31:0] rd_mux  =
    grp_hit ? (reg_addr[2] ? {19'h0, xpk_ff[grp_idx]} : {23'h0, thr_ff[grp_idx]}) :
    reg_addr == flloc_pkg::A_CTRL   ? {20'h0, ctrl_ff} :
    reg_addr == flloc_pkg::A_STS    ? {28'h0, sts_ff} :
    reg_addr == flloc_pkg::A_MASK   ? {28'h0, mask_ff} :
    reg_addr == flloc_pkg::A_CNT    ? cnt_ff :
    reg_addr == flloc_pkg::A_CTNOM  ? {16'h0, ctnom_ff} :
    reg_addr == flloc_pkg::A_RSEL   ? {28'h0, rsel_ff} :
    reg_addr == flloc_pkg::A_RSTAMP ? rec_rd.stamp :
    reg_addr == flloc_pkg::A_RINFO  ? {19'h0, rec_rd.calc, 1'b0, rec_rd.grp, 2'h0, rec_rd.dir,
                                       1'b0, rec_rd.ftype} :
    reg_addr == flloc_pkg::A_RX     ? rec_rd.x_mohm :
    reg_addr == flloc_pkg::A_RI     ? {16'h0, rec_rd.i_pu} :
    reg_addr == flloc_pkg::A_RIPRI  ? rec_rd.i_pri :
    reg_addr == flloc_pkg::A_RDIST  ? rec_rd.dist_m :
    reg_addr == flloc_pkg::A_RNUM   ? {28'h0, num_ff} : 32'h0;

  for (genvar g = 0; g < flloc_pkg::NGRP; g++) begin : g_set
    always_ff @(posedge clk) begin
      if (rst) begin
        thr_ff[g] <= flloc_pkg::THR_RST;
        xpk_ff[g] <= flloc_pkg::XPK_RST;
      end else if (reg_wr && grp_hit && grp_idx == 3'(g)) begin
        if (reg_addr[2]) begin
          xpk_ff[g] <= reg_wdata[12:0];
        end else begin
          thr_ff[g] <= reg_wdata[8:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_ff  <= flloc_pkg::CTRL_RST;
      mask_ff  <= 4'h0;
      ctnom_ff <= flloc_pkg::CTNOM_RST;
      rsel_ff  <= 4'h0;
      sts_ff   <= 4'h0;
      cnt_ff   <= 32'h0;
      rdata_ff <= 32'h0;
      irq_ff   <= 1'b0;
    end else begin
      if (reg_wr && reg_addr == flloc_pkg::A_CTRL)  ctrl_ff  <= reg_wdata[11:0];
      if (reg_wr && reg_addr == flloc_pkg::A_MASK)  mask_ff  <= reg_wdata[3:0];
      if (reg_wr && reg_addr == flloc_pkg::A_CTNOM) ctnom_ff <= reg_wdata[15:0];
      if (reg_wr && reg_addr == flloc_pkg::A_RSEL)  rsel_ff  <= (reg_wdata[3:0] < 4'(flloc_pkg::HIST)) ?
                                                                reg_wdata[3:0] : rsel_ff;
      // a fresh event beats a clear in the same clock
      sts_ff   <= (sts_ff & ~(wr_sts ? reg_wdata[3:0] : 4'h0)) | ev_sts;
      cnt_ff   <= wr_cnt ? 32'(trig_rise) : cnt_ff + 32'(trig_rise);
      rdata_ff <= reg_rd ? rd_mux : 32'h0;
      irq_ff   <= |(((sts_ff & ~(wr_sts ? reg_wdata[3:0] : 4'h0)) | ev_sts) & mask_ff);
    end
  end

  assign reg_rdata = rdata_ff;
  assign evt_valid = evt_valid_ff;
  assign evt_code  = evt_code_ff;
  assign evt_stamp = evt_stamp_ff;
  assign blocked   = blk_ff;
  assign irq       = irq_ff;

  // checks
  property p_trig_start;
    @(posedge clk) disable iff (rst)
    (trig_rise && !calc_block && st_ff == flloc_pkg::S_IDLE) |=> st_ff == flloc_pkg::S_EVAL;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start evaluation");
  property p_block;
    @(posedge clk) disable iff (rst)
    (trig_rise && calc_block) |=> blocked && st_ff != flloc_pkg::S_EVAL;
  endproperty
  a_block: assert property (p_block) else $error("blocked trigger was processed");
  property p_blk_idle;
    @(posedge clk) disable iff (rst)
    (trig_rise && calc_block && st_ff == flloc_pkg::S_IDLE) |=> st_ff == flloc_pkg::S_IDLE;
  endproperty
  a_blk_idle: assert property (p_blk_idle) else $error("blocked trigger left idle");
  property p_noloop;
    @(posedge clk) disable iff (rst)
    (st_ff == flloc_pkg::S_EVAL && !ov_a && !ov_b && !ov_c) |=> st_ff == flloc_pkg::S_IDLE;
  endproperty
  a_noloop: assert property (p_noloop) else $error("record made without current");
  property p_pe;
    @(posedge clk) disable iff (rst)
    (st_ff == flloc_pkg::S_EVAL && !pe_ff && (ov_a + ov_b + ov_c) == 2'h1) |-> ft_sel == flloc_pkg::FT_NONE;
  endproperty
  a_pe: assert property (p_pe) else $error("phase-neutral loop without earth voltage");
  property p_abc;
    @(posedge clk) disable iff (rst)
    (st_ff == flloc_pkg::S_EVAL && ov_a && ov_b && ov_c) |=> ft_ff == flloc_pkg::FT_ABC;
  endproperty
  a_abc: assert property (p_abc) else $error("three-phase loop wrong");
  property p_count;
    @(posedge clk) disable iff (rst)
    (trig_rise && !wr_cnt) |=> cnt_ff == $past(cnt_ff) + 32'h1;
  endproperty
  a_count: assert property (p_count) else $error("trigger not counted");
  property p_hist;
    @(posedge clk) disable iff (rst)
    (store && num_ff == 4'(flloc_pkg::HIST)) |=> num_ff == 4'(flloc_pkg::HIST) && wp_ff != $past(wp_ff);
  endproperty
  a_hist: assert property (p_hist) else $error("history depth wrong");
  property p_evt_en;
    @(posedge clk) disable iff (rst)
    evt_valid |-> $past(ctrl_ff[8 + ev_idx]);
  endproperty
  a_evt_en: assert property (p_evt_en) else $error("disabled event stored");
  property p_sts_win;
    @(posedge clk) disable iff (rst)
    trig_rise |=> sts_ff[0];
  endproperty
  a_sts_win: assert property (p_sts_win) else $error("trigger status lost to a clear");
  property p_store;
    @(posedge clk) disable iff (rst)
    (st_ff == flloc_pkg::S_DIVD && div_end && dvs_ff != 32'h0) |->
      64'(q_ff) * 64'(dvs_ff) <= 64'(d_chk) && 64'(d_chk) < (64'(q_ff) + 64'h1) * 64'(dvs_ff);
  endproperty
  a_store: assert property (p_store) else $error("distance quotient wrong");
endmodule
`default_nettype wire

// ---- rtl/flloc_pkg.sv ----
// fault distance locator: shared constants, register map, record layout
// assumes one 250 MHz clock domain; all widths fixed
package flloc_pkg;
  localparam int         TRIG_W     = 32;
  localparam int         HIST       = 12;
  localparam int         NGRP       = 8;
  localparam logic [7:0] A_CTRL     = 8'h00;
  localparam logic [7:0] A_STS      = 8'h04;
  localparam logic [7:0] A_MASK     = 8'h08;
  localparam logic [7:0] A_CNT      = 8'h0c;
  localparam logic [7:0] A_CTNOM    = 8'h10;
  localparam logic [7:0] A_RSEL     = 8'h14;
  localparam logic [7:0] A_RSTAMP   = 8'h18;
  localparam logic [7:0] A_RINFO    = 8'h1c;
  localparam logic [7:0] A_RX       = 8'h20;
  localparam logic [7:0] A_RI       = 8'h24;
  localparam logic [7:0] A_RIPRI    = 8'h28;
  localparam logic [7:0] A_RDIST    = 8'h2c;
  localparam logic [7:0] A_RNUM     = 8'h30;
  localparam logic [1:0] A_GRP_HI   = 2'h1;
  localparam logic [11:0] CTRL_RST  = 12'hf00;
  localparam logic [8:0] THR_RST    = 9'h00a;
  localparam logic [12:0] XPK_RST   = 13'h007d;
  localparam logic [15:0] CTNOM_RST = 16'h0064;
  localparam logic [3:0] THR_SCALE  = 4'ha;
  localparam logic [13:0] X_SCALE   = 14'h2710;
  localparam logic [9:0] D_SCALE    = 10'h3e8;
  localparam int         ST_TRIG    = 0;
  localparam int         ST_CALC    = 1;
  localparam int         ST_BLK     = 2;
  localparam int         ST_NOLOOP  = 3;
  localparam int         EV_TRIG_ON = 0;
  localparam int         EV_TRIG_OFF = 1;
  localparam int         EV_CALC_ON = 2;
  localparam int         EV_CALC_OFF = 3;

  typedef enum logic [2:0] {
    FT_NONE = 3'h0, FT_AB = 3'h1, FT_BC = 3'h2, FT_CA = 3'h3,
    FT_AN   = 3'h4, FT_BN = 3'h5, FT_CN = 3'h6, FT_ABC = 3'h7
  } flloc_ftype_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_EVAL = 3'h1, S_DIVX = 3'h3, S_DIVD = 3'h2, S_STORE = 3'h6
  } flloc_state_t;

  // currents in 0.01 x nominal, voltages in 0.1 V
  typedef struct packed {
    logic [15:0] i_a;
    logic [15:0] i_b;
    logic [15:0] i_c;
    logic [15:0] u_ab;
    logic [15:0] u_bc;
    logic [15:0] u_ca;
    logic [15:0] u_an;
    logic [15:0] u_bn;
    logic [15:0] u_cn;
  } flloc_meas_t;

  typedef struct packed {
    logic [31:0]  stamp;
    logic         calc;
    flloc_ftype_t ftype;
    logic [1:0]   dir;
    logic [2:0]   grp;
    logic [31:0]  x_mohm;
    logic [15:0]  i_pu;
    logic [31:0]  i_pri;
    logic [31:0]  dist_m;
  } flloc_rec_t;
endpackage

// ---- sim/flloc_far_model.sv ----
// far-side model: program-cycle tick and millisecond time base
// assumes the bench clock and a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module flloc_far_model #(
  parameter int TICK_DIV = 8
) (
  input  wire logic        clk,
  input  wire logic        rst,
  output logic             tick,
  output logic [31:0]      time_ms
);
  logic [7:0]  div_ff;
  logic        tick_ff;
  logic [31:0] time_ff;
  // shortened: one tick stands for one 5 ms refresh, time moves once per tick
  always_ff @(posedge clk) begin
    if (rst) begin
      div_ff  <= 8'h00;
      tick_ff <= 1'b0;
      time_ff <= 32'h0000_0000;
    end else begin
      div_ff  <= (div_ff == 8'(TICK_DIV - 1)) ? 8'h00 : div_ff + 8'h01;
      tick_ff <= (div_ff == 8'(TICK_DIV - 1));
      time_ff <= time_ff + {31'h0, tick_ff};
    end
  end
  assign tick    = tick_ff;
  assign time_ms = time_ff;
endmodule
`default_nettype wire

// ---- sim/fault_distance_locator_tb_top.sv ----
// locator bench: register tasks, trigger sequences, event monitor
// assumes flloc_far_model supplies tick and time; bench drives the rest
`timescale 1ns/1ps
`default_nettype none
module fault_distance_locator_tb_top;
  logic                   clk, rst, tick, calc_block, pe_volt_ok, reg_wr, reg_rd, evt_valid, blocked, irq;
  logic [31:0]            trig_src, time_ms, reg_wdata, reg_rdata, evt_stamp, rv, xv;
  logic [7:0]             reg_addr;
  logic [2:0]             set_group;
  logic [1:0]             fault_dir, evt_code;
  flloc_pkg::flloc_meas_t meas;
  int                     errors, total_checks, ev_cnt[4];
  logic [2:0]             tph[11] = '{3'h7, 3'h3, 3'h6, 3'h5, 3'h1, 3'h2, 3'h4, 3'h3, 3'h6, 3'h5, 3'h7};
  logic [2:0]             tft[11] = '{3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h1, 3'h2, 3'h3, 3'h7};

  flloc_far_model flloc_far_model_i (.clk(clk), .rst(rst), .tick(tick), .time_ms(time_ms));
  flloc_top flloc_top_i (.clk(clk), .rst(rst), .tick(tick), .trig_src(trig_src), .calc_block(calc_block),
    .pe_volt_ok(pe_volt_ok), .meas(meas), .fault_dir(fault_dir), .set_group(set_group), .time_ms(time_ms),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .evt_valid(evt_valid), .evt_code(evt_code), .evt_stamp(evt_stamp), .blocked(blocked), .irq(irq));

  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic rc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    chk(nm, exp, rv);
  endtask
  function automatic logic [31:0] expinfo(input logic [2:0] ft, input logic [2:0] g, input logic [1:0] d);
    return {19'h0, 1'b1, 1'b0, g, 2'h0, d, 1'b0, ft};
  endfunction
  // over threshold is 1.5 x nominal, under is 0.5 x nominal
  task automatic fire(input logic [2:0] ph, input logic pe, input logic blk, input logic [1:0] d, input int b);
    @(posedge clk);
    meas.i_a    <= ph[0] ? 16'h0096 : 16'h0032;
    meas.i_b    <= ph[1] ? 16'h0096 : 16'h0032;
    meas.i_c    <= ph[2] ? 16'h0096 : 16'h0032;
    fault_dir   <= d;
    pe_volt_ok  <= pe;
    calc_block  <= blk;
    trig_src    <= 32'h1 << b;
    repeat (100) @(posedge clk);
    chk("blocked", {31'h0, blk}, {31'h0, blocked});
    trig_src    <= 32'h0;
    calc_block  <= 1'b0;
    repeat (24) @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (evt_valid === 1'b1) begin
      ev_cnt[evt_code]++;
      chk("evt_age", 32'h0, {31'h0, (time_ms - evt_stamp) > 32'h1});
    end
  end
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #200000;
    errors++;
    close_out();
  end
  initial begin
    errors = 0;
    total_checks = 0;
    ev_cnt = '{0, 0, 0, 0};
    {calc_block, pe_volt_ok, reg_wr, reg_rd} = 4'h0;
    {trig_src, reg_wdata, reg_addr, set_group, fault_dir} = '0;
    meas = '{16'h0032, 16'h0032, 16'h0032, 16'h03e8, 16'h03e8, 16'h03e8, 16'h0240, 16'h0240, 16'h0240};
    rst = 1'b1;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rc("ctrl", flloc_pkg::A_CTRL, 32'h0000_0f00);
    rc("thr0", 8'h40, 32'h0000_000a);
    rc("xpk0", 8'h44, 32'h0000_007d);
    rc("unmapped", 8'hfc, 32'h0);
    $display("test reset_values done");
    wr(flloc_pkg::A_MASK, 32'h2);
    wr(flloc_pkg::A_RSEL, 32'h0);
    fire(3'h3, 1'b1, 1'b0, 2'h1, 0);
    chk("irq_set", 32'h1, {31'h0, irq});
    rc("info", flloc_pkg::A_RINFO, expinfo(3'h1, 3'h0, 2'h1));
    rc("ipu", flloc_pkg::A_RI, 32'd150);
    rc("ipri", flloc_pkg::A_RIPRI, 32'd15000);
    rd(flloc_pkg::A_RX);
    xv = rv;
    chk("x_ab", 32'd333, xv);
    rc("dist", flloc_pkg::A_RDIST, xv * 32'd1000 / 32'd125);
    wr(flloc_pkg::A_STS, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq_clr", 32'h0, {31'h0, irq});
    $display("test first_record done");
    wr(8'h4c, 32'd250);
    @(posedge clk);
    set_group <= 3'h1;
    fire(3'h6, 1'b1, 1'b0, 2'h2, 0);
    rc("info_g1", flloc_pkg::A_RINFO, expinfo(3'h2, 3'h1, 2'h2));
    rd(flloc_pkg::A_RX);
    xv = rv;
    chk("x_bc", 32'd333, xv);
    rc("dist_g1", flloc_pkg::A_RDIST, xv * 32'd1000 / 32'd250);
    set_group <= 3'h0;
    $display("test group_change done");
    for (int k = 0; k < 11; k++) begin
      fire(tph[k], k < 7, 1'b0, 2'(k % 3), 0);
      rc("info_loop", flloc_pkg::A_RINFO, expinfo(tft[k], 3'h0, 2'(k % 3)));
    end
    rc("records", flloc_pkg::A_RNUM, 32'd12);
    wr(flloc_pkg::A_RSEL, 32'h1);
    wr(flloc_pkg::A_RSEL, 32'hc);
    rc("info_age1", flloc_pkg::A_RINFO, expinfo(3'h3, 3'h0, 2'h0));
    rc("rsel_keep", flloc_pkg::A_RSEL, 32'h1);
    wr(flloc_pkg::A_RSEL, 32'h0);
    $display("test loop_table done");
    wr(flloc_pkg::A_STS, 32'hf);
    fire(3'h1, 1'b0, 1'b0, 2'h0, 0);
    rc("sts_noloop", flloc_pkg::A_STS, 32'h9);
    wr(flloc_pkg::A_STS, 32'hf);
    fire(3'h3, 1'b1, 1'b1, 2'h0, 0);
    rc("sts_block", flloc_pkg::A_STS, 32'h5);
    rc("count", flloc_pkg::A_CNT, 32'd15);
    $display("test block_noloop done");
    wr(flloc_pkg::A_CTRL, 32'he05);
    ev_cnt = '{0, 0, 0, 0};
    fire(3'h3, 1'b1, 1'b0, 2'h0, 3);
    rc("count_other", flloc_pkg::A_CNT, 32'd15);
    fire(3'h3, 1'b1, 1'b0, 2'h0, 5);
    rc("count_sel", flloc_pkg::A_CNT, 32'd16);
    chk("ev_trig_on", 32'd0, ev_cnt[0]);
    chk("ev_trig_off", 32'd1, ev_cnt[1]);
    chk("ev_calc_on", 32'd1, ev_cnt[2]);
    chk("ev_calc_off", 32'd1, ev_cnt[3]);
    wr(flloc_pkg::A_CNT, 32'h0);
    rc("count_clr", flloc_pkg::A_CNT, 32'd0);
    $display("test select_events done");
    close_out();
  end
endmodule
`default_nettype wire
